// ### core/pwm_fault_regs.svh
/*
 * Register offsets, field positions, reset values and timing figures
 * of one PWM generator channel with fault, trigger and blanking.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one word a register.
 */
`ifndef PWM_FAULT_REGS_SVH
`define PWM_FAULT_REGS_SVH

// byte offsets
`define OFS_TRIG 8'h00
`define OFS_LEB 8'h04
`define OFS_FCL 8'h08
`define OFS_DUTY 8'h0C
`define OFS_PER 8'h10
`define OFS_PHASE 8'h14
`define OFS_CTRL 8'h18
`define OFS_STAT 8'h1C

// reset values
`define RST_TRIG 16'h0000
`define RST_LEB 16'h0000
`define RST_FCL 16'h0000
`define RST_CTRL 16'h0000
`define RST_TB 13'h0000

// writable bits (unimplemented bits read as zero)
`define MSK_TRIG 16'hFFF8
`define MSK_LEB 16'hFFF8
`define MSK_FCL 16'h1FFF
`define MSK_CTRL 16'h00FF

// trigger compare
`define TRG_MSB 15
`define TRG_LSB 3
// edge blanking control
`define LEB_HR 15
`define LEB_HF 14
`define LEB_LR 13
`define LEB_LF 12
`define LEB_FEN 11
`define LEB_CEN 10
`define LEB_MSB 9
`define LEB_LSB 3
// fault and limit control
`define FCL_CSRC_MSB 12
`define FCL_CSRC_LSB 9
`define FCL_CPOL 8
`define FCL_CMODE 7
`define FCL_FSRC_MSB 6
`define FCL_FSRC_LSB 3
`define FCL_FPOL 2
`define FCL_FMOD_MSB 1
`define FCL_FMOD_LSB 0
// channel control
`define CTL_EN 0
`define CTL_PMOD_MSB 2
`define CTL_PMOD_LSB 1
`define CTL_MPH 3
`define CTL_FDAT_MSB 5
`define CTL_FDAT_LSB 4
`define CTL_CDAT_MSB 7
`define CTL_CDAT_LSB 6
`define CTL_FCLR 8

// timing
`define LEB_STEP_NS 8
`define CLK_PERIOD_NS 50

`endif

// ### core/pwm_fault_pkg.sv
/*
 * Types shared by the PWM fault and blanking channel.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwm_fault_pkg;

  typedef enum logic [1:0] {
    FM_LATCH = 2'b00,
    FM_CYCLE = 2'b01,
    FM_RSVD = 2'b10,
    FM_OFF = 2'b11
  } fault_mode_t;

  typedef enum logic [1:0] {
    PM_COMP = 2'b00,
    PM_INDEP = 2'b01,
    PM_PUSH = 2'b10,
    PM_RSVD = 2'b11
  } pin_mode_t;

  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP = 2'b10
  } wr_state_t;

endpackage : pwm_fault_pkg

// ### core/edge_blank.sv
/*
 * Leading-edge blanking timer: selected output edges start a window
 * measured in nanoseconds and counted down by the clock period.
 * Assumes the output levels it watches come from flip-flops on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_regs.svh"

module edge_blank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic high_lvl,
  input wire logic low_lvl,
  input wire logic [3:0] edge_en,
  input wire logic [6:0] duration,
  output logic blank_ff
);

  localparam logic [9:0] STEP_NS = 10'(`LEB_STEP_NS);
  localparam logic [9:0] CLK_NS = 10'(`CLK_PERIOD_NS);

  logic high_d_ff;
  logic low_d_ff;
  logic [9:0] left_ns_ff;
  logic [9:0] nxt_left_ns;
  logic start;

  // order: high rise, high fall, low rise, low fall
  assign start = |(edge_en & {high_lvl & ~high_d_ff,
                              ~high_lvl & high_d_ff,
                              low_lvl & ~low_d_ff,
                              ~low_lvl & low_d_ff});

  // remaining time rounds up to whole clock cycles
  assign nxt_left_ns = start ? 10'({3'b000, duration} * STEP_NS)
                     : (left_ns_ff > CLK_NS) ? 10'(left_ns_ff - CLK_NS)
                     : 10'h000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_d_ff <= 1'b0;
      low_d_ff <= 1'b0;
      left_ns_ff <= 10'h000;
      blank_ff <= 1'b0;
    end else begin
      high_d_ff <= high_lvl;
      low_d_ff <= low_lvl;
      left_ns_ff <= nxt_left_ns;
      blank_ff <= (nxt_left_ns != 10'h000);
    end
  end

endmodule : edge_blank

`default_nettype wire

// ### core/pwm_fault_channel.sv
/*
 * One PWM generator channel: time base, duty compare, output modes,
 * fault and current-limit handling, trigger compare and blanking,
 * with its registers on an AXI4-Lite slave.
 * Assumes fault and comparator inputs arrive asynchronously to aclk.
 */
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
// Contract
// - 4-bit code picks the fault source
// - polarity bit one means fault active low
// - mode 00 latches fault output values
// - mode 01 forces fault values per cycle
// - mode 11 ignores fault; 10 reserved
// - 13-bit compare against time base triggers
// - compare value zero never triggers
// - four bits pick edges starting blanking
// - fault blanking enable masks fault input
// - limit blanking enable masks limit input
// - 7-bit duration in 8 ns steps
// - output on while count within duty
// - output off once count exceeds duty
// - counter restarts after passing period
// - complementary: low is inverse of high
// - push-pull alternates pulse between pins
// - multi-phase adds shift to time base
// - upper fault bit high, lower low
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_regs.svh"

module pwm_fault_channel
  import pwm_fault_pkg::*;
#(
  parameter int TB_W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] comparator,
  input wire logic shared_fault_one,
  input wire logic shared_fault_two,
  input wire logic shared_fault_three,
  input wire logic shared_fault_four,
  input wire logic independent_fault_two,
  input wire logic independent_fault_four,
  output logic high_side_output,
  output logic low_side_output,
  output logic adc_trigger
);

  if (TB_W != 13) begin : g_check
    $error("time base must be 13 bits wide");
  end

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // reserved codes give no source, so polarity cannot invent a fault
  function automatic logic src_active(input logic [3:0] code,
                                      input logic pol,
                                      input logic [9:0] pins);
    logic hit;
    logic lvl;
    hit = 1'b1;
    lvl = 1'b0;
    if (code[3:2] == 2'b00) begin
      lvl = pins[code[1:0]];
    end else if (code[3:2] == 2'b10) begin
      lvl = pins[4 + {2'b00, code[1:0]}];
    end else if (code == 4'hD) begin
      lvl = pins[8];
    end else if (code == 4'hF) begin
      lvl = pins[9];
    end else begin
      hit = 1'b0;
    end
    return hit & (lvl ^ pol);
  endfunction : src_active

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0]) begin
      val[7:0] = data[7:0];
    end
    if (strb[1]) begin
      val[15:8] = data[15:8];
    end
    return val & mask;
  endfunction : merge

  // pin synchronisers
  logic [9:0] pins_raw;
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  logic [9:0] sync3_ff;
  logic [9:0] pins_ff;
  logic [9:0] agree;

  assign pins_raw = {independent_fault_four, independent_fault_two,
                     shared_fault_four, shared_fault_three,
                     shared_fault_two, shared_fault_one, comparator};
  assign agree = ~(sync2_ff ^ sync3_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
      sync3_ff <= 10'h000;
      pins_ff <= 10'h000;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pins_ff <= (sync2_ff & agree) | (pins_ff & ~agree);
    end
  end

  // registers
  logic [15:0] trig_ff;
  logic [15:0] leb_ff;
  logic [15:0] fcl_ff;
  logic [15:0] ctrl_ff;
  logic [TB_W-1:0] duty_ff;
  logic [TB_W-1:0] per_ff;
  logic [TB_W-1:0] phase_ff;

  // write channel
  wr_state_t ws_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_fire;
  logic w_fire;
  logic do_wr;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic wr_hit;
  logic [15:0] wr_tb;
  logic [15:0] wr_per;
  logic [15:0] wr_ph;

  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign do_wr = (ws_ff == WS_COLLECT) & aw_got_ff & w_got_ff;
  assign nxt_aw_got = (aw_got_ff & ~do_wr) | aw_fire;
  assign nxt_w_got = (w_got_ff & ~do_wr) | w_fire;
  assign wr_hit = (waddr_ff[7:2] <= `OFS_CTRL >> 2)
                & (waddr_ff[1:0] == 2'b00);
  assign wr_tb = merge(16'(duty_ff), wdata_ff, wstrb_ff, 16'hFFFF);
  assign wr_per = merge(16'(per_ff), wdata_ff, wstrb_ff, 16'hFFFF);
  assign wr_ph = merge(16'(phase_ff), wdata_ff, wstrb_ff, 16'hFFFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_ff <= WS_COLLECT;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      s_axi_awready <= ~nxt_aw_got;
      s_axi_wready <= ~nxt_w_got;
      if (aw_fire) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      case (ws_ff)
        WS_COLLECT: begin
          if (do_wr) begin
            ws_ff <= WS_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            ws_ff <= WS_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          ws_ff <= WS_COLLECT;
        end
      endcase
    end
  end

  logic fault_clr;
  assign fault_clr = do_wr & (waddr_ff == `OFS_CTRL) & wstrb_ff[1]
                   & wdata_ff[`CTL_FCLR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_ff <= `RST_TRIG;
      leb_ff <= `RST_LEB;
      fcl_ff <= `RST_FCL;
      ctrl_ff <= `RST_CTRL;
      duty_ff <= `RST_TB;
      per_ff <= `RST_TB;
      phase_ff <= `RST_TB;
    end else if (do_wr) begin
      if (waddr_ff == `OFS_TRIG) begin
        trig_ff <= merge(trig_ff, wdata_ff, wstrb_ff, `MSK_TRIG);
      end else if (waddr_ff == `OFS_LEB) begin
        leb_ff <= merge(leb_ff, wdata_ff, wstrb_ff, `MSK_LEB);
      end else if (waddr_ff == `OFS_FCL) begin
        fcl_ff <= merge(fcl_ff, wdata_ff, wstrb_ff, `MSK_FCL);
      end else if (waddr_ff == `OFS_CTRL) begin
        ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff, `MSK_CTRL);
      end else if (waddr_ff == `OFS_DUTY) begin
        duty_ff <= wr_tb[TB_W-1:0];
      end else if (waddr_ff == `OFS_PER) begin
        per_ff <= wr_per[TB_W-1:0];
      end else if (waddr_ff == `OFS_PHASE) begin
        phase_ff <= wr_ph[TB_W-1:0];
      end
    end
  end

  // field views
  logic enable;
  pin_mode_t pmod;
  fault_mode_t fmod;
  logic [1:0] fdat;
  logic [1:0] cdat;
  logic [TB_W-1:0] trg_val;

  assign enable = ctrl_ff[`CTL_EN];
  assign pmod = pin_mode_t'(ctrl_ff[`CTL_PMOD_MSB:`CTL_PMOD_LSB]);
  assign fmod = fault_mode_t'(fcl_ff[`FCL_FMOD_MSB:`FCL_FMOD_LSB]);
  assign fdat = ctrl_ff[`CTL_FDAT_MSB:`CTL_FDAT_LSB];
  assign cdat = ctrl_ff[`CTL_CDAT_MSB:`CTL_CDAT_LSB];
  assign trg_val = trig_ff[`TRG_MSB:`TRG_LSB];

  // time base
  logic [TB_W-1:0] ptb_ff;
  logic [TB_W-1:0] tmr;
  logic wrap;
  logic pp_ff;

  assign wrap = (ptb_ff >= per_ff);
  assign tmr = ctrl_ff[`CTL_MPH] ? TB_W'(ptb_ff + phase_ff)
                                 : ptb_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      ptb_ff <= `RST_TB;
      pp_ff <= 1'b0;
    end else if (wrap) begin
      ptb_ff <= `RST_TB;
      pp_ff <= ~pp_ff;
    end else begin
      ptb_ff <= TB_W'(ptb_ff + 1'b1);
    end
  end

  // fault and current limit
  logic blank;
  logic flt_sel;
  logic cl_sel;
  logic flt_on;
  logic cl_on;
  logic flt_latch_ff;
  logic flt_cyc_ff;
  logic cl_cyc_ff;

  assign flt_sel = src_active(
    fcl_ff[`FCL_FSRC_MSB:`FCL_FSRC_LSB],
    fcl_ff[`FCL_FPOL], pins_ff);
  assign cl_sel = src_active(
    fcl_ff[`FCL_CSRC_MSB:`FCL_CSRC_LSB],
    fcl_ff[`FCL_CPOL], pins_ff);
  // reserved mode acts like disabled
  assign flt_on = enable & flt_sel
                & ((fmod == FM_LATCH) | (fmod == FM_CYCLE))
                & ~(blank & leb_ff[`LEB_FEN]);
  assign cl_on = enable & cl_sel & fcl_ff[`FCL_CMODE]
               & ~(blank & leb_ff[`LEB_CEN]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_latch_ff <= 1'b0;
      flt_cyc_ff <= 1'b0;
      cl_cyc_ff <= 1'b0;
    end else begin
      // a new fault wins over a software clear in the same cycle
      if (flt_on & (fmod == FM_LATCH)) begin
        flt_latch_ff <= 1'b1;
      end else if (fault_clr) begin
        flt_latch_ff <= 1'b0;
      end
      if (flt_on & (fmod == FM_CYCLE)) begin
        flt_cyc_ff <= 1'b1;
      end else if (wrap | ~enable) begin
        flt_cyc_ff <= 1'b0;
      end
      if (cl_on) begin
        cl_cyc_ff <= 1'b1;
      end else if (wrap | ~enable) begin
        cl_cyc_ff <= 1'b0;
      end
    end
  end

  // output generation
  logic act;
  logic base_h;
  logic base_l;
  logic flt_force;
  logic cl_force;
  logic nxt_high;
  logic nxt_low;

  assign act = (tmr <= duty_ff);
  assign base_h = (pmod == PM_PUSH) ? act & ~pp_ff
                : (pmod == PM_RSVD) ? 1'b0
                : act;
  assign base_l = (pmod == PM_PUSH) ? act & pp_ff
                : (pmod == PM_COMP) ? ~act
                : (pmod == PM_INDEP) ? act
                : 1'b0;
  assign flt_force = flt_on | flt_latch_ff | flt_cyc_ff;
  assign cl_force = cl_on | cl_cyc_ff;
  // fault outranks current limit
  assign nxt_high = !enable ? 1'b0
                  : flt_force ? fdat[1]
                  : cl_force ? cdat[1]
                  : base_h;
  assign nxt_low = !enable ? 1'b0
                 : flt_force ? fdat[0]
                 : cl_force ? cdat[0]
                 : base_l;

  logic nxt_trig;
  assign nxt_trig = enable & (trg_val != '0)
                  & (tmr == trg_val);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
      adc_trigger <= 1'b0;
    end else begin
      high_side_output <= nxt_high;
      low_side_output <= nxt_low;
      adc_trigger <= nxt_trig;
    end
  end

  edge_blank u_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .high_lvl(high_side_output),
    .low_lvl(low_side_output),
    .edge_en(leb_ff[`LEB_HR:`LEB_LF]),
    .duration(leb_ff[`LEB_MSB:`LEB_LSB]),
    .blank_ff(blank)
  );

  // read channel
  logic [31:0] stat;
  logic rd_hit;
  logic [31:0] rd_val;
  logic ar_fire;
  logic nxt_rvalid;

  assign stat = {3'b000, ptb_ff, 10'h000, blank, low_side_output,
                 high_side_output, cl_cyc_ff, flt_cyc_ff,
                 flt_latch_ff};
  assign rd_hit = (s_axi_araddr[1:0] == 2'b00)
                & (s_axi_araddr[7:2] <= `OFS_STAT >> 2);
  assign rd_val = (s_axi_araddr == `OFS_TRIG) ? {16'h0000, trig_ff}
                : (s_axi_araddr == `OFS_LEB) ? {16'h0000, leb_ff}
                : (s_axi_araddr == `OFS_FCL) ? {16'h0000, fcl_ff}
                : (s_axi_araddr == `OFS_DUTY) ? 32'(duty_ff)
                : (s_axi_araddr == `OFS_PER) ? 32'(per_ff)
                : (s_axi_araddr == `OFS_PHASE) ? 32'(phase_ff)
                : (s_axi_araddr == `OFS_CTRL) ? {16'h0000, ctrl_ff}
                : (s_axi_araddr == `OFS_STAT) ? stat
                : 32'h0000_0000;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign nxt_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid <= nxt_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : pwm_fault_channel

`default_nettype wire

// ### verif/pwm_fault_channel_properties.sv
/*
 * Port checks of the PWM fault channel: bus handshake timing and the
 * width of the converter trigger pulse.
 * Assumes it is bound to pwm_fault_channel and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module pwm_fault_channel_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adc_trigger
);
  default clocking dclk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after take");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("awready high right after take");
  w_refuse_a: assert property (s_axi_wvalid && s_axi_wready
    |=> !s_axi_wready) else $error("wready high right after take");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid kept after bready");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed one cycle after rready");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while read data pending");
  trig_pulse_a: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger pulse longer than one cycle");
endmodule : pwm_fault_channel_properties

bind pwm_fault_channel pwm_fault_channel_properties props_i (.*);

`default_nettype wire

// ### verif/converter_model.sv
/*
 * Converter side of the channel: fault and comparator lines, and
 * counters of switch-pin and trigger activity.
 * Assumes the bench pulses clr to start a counting window.
 */
`timescale 1ns/1ps
`default_nettype none

module converter_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic high_side_output,
  input wire logic low_side_output,
  input wire logic adc_trigger,
  input wire logic [9:0] fault_req,
  output logic [9:0] fault_pins,
  output var int hi_n,
  output var int lo_n,
  output var int tr_n,
  output var int same_n
);
  // fault lines move off the clock edge, as real comparators do
  assign #7 fault_pins = fault_req;

  always_ff @(posedge aclk) begin
    if (clr) begin
      hi_n <= 0;
      lo_n <= 0;
      tr_n <= 0;
      same_n <= 0;
    end else begin
      hi_n <= hi_n + (high_side_output === 1'b1);
      lo_n <= lo_n + (low_side_output === 1'b1);
      tr_n <= tr_n + (adc_trigger === 1'b1);
      same_n <= same_n + (high_side_output === low_side_output);
    end
  end
endmodule : converter_model

`default_nettype wire

// ### verif/tb.sv
/*
 * Self-checking bench of the PWM fault channel: registers over
 * AXI4-Lite, output modes, trigger, fault sources and blanking.
 * Assumes period 9 and duty 3, so a 20-cycle window spans two periods.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_fault_regs.svh"

module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr;
  logic awready, wready, bvalid, arready, rvalid, hs, ls, trg;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] fault_req;
  wire logic [9:0] fp;
  int hi_n, lo_n, tr_n, same_n, miscompares, tests_run, code;
  logic [31:0] quiet [5] = '{32'h21, 32'h61, 32'h71, 32'h2, 32'h3};

  pwm_fault_channel DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comparator(fp[3:0]), .shared_fault_one(fp[4]),
    .shared_fault_two(fp[5]), .shared_fault_three(fp[6]),
    .shared_fault_four(fp[7]), .independent_fault_two(fp[8]),
    .independent_fault_four(fp[9]), .high_side_output(hs),
    .low_side_output(ls), .adc_trigger(trg)
  );

  converter_model conv (
    .aclk(aclk), .clr(clr), .high_side_output(hs), .low_side_output(ls),
    .adc_trigger(trg), .fault_req(fault_req), .fault_pins(fp),
    .hi_n(hi_n), .lo_n(lo_n), .tr_n(tr_n), .same_n(same_n)
  );

  always #25 aclk = ~aclk;

  task automatic test_done();
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    chk(bvalid, 1'b1);
    chk(bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'b00);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    chk(rdata, e);
    chk(rresp, er);
  endtask : rd

  // settle long enough for sync, period wrap and blanking windows
  task automatic meas(input int h, input int l, input int t, input int s);
    repeat (30) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (20) @(posedge aclk);
    #1;
    chk(hi_n, h);
    chk(lo_n, l);
    chk(tr_n, t);
    chk(same_n, s);
  endtask : meas

  initial begin
    #1_000_000;
    miscompares++;
    test_done();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, clr} = 4'h0;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h0;
    wstrb = 4'hF;
    // responses always accepted at once
    bready = 1'b1;
    rready = 1'b1;
    fault_req = 10'h000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_TRIG, `RST_TRIG);
    rd(`OFS_LEB, `RST_LEB);
    rd(`OFS_FCL, `RST_FCL);
    rd(`OFS_CTRL, `RST_CTRL);
    rd(8'h20, 32'h0, 2'b10);
    wr(8'h20, 32'hFFFF, 2'b10);
    wr(`OFS_TRIG, 32'hFFFFFFFF);
    rd(`OFS_TRIG, 32'hFFF8);
    wr(`OFS_LEB, 32'hFFFFFFFF);
    rd(`OFS_LEB, 32'hFFF8);
    wr(`OFS_FCL, 32'hFFFFFFFF);
    rd(`OFS_FCL, 32'h1FFF);
    wr(`OFS_LEB, 32'h0);
    wr(`OFS_FCL, 32'h3);
    wr(`OFS_PER, 32'h9);
    wr(`OFS_DUTY, 32'h3);
    wr(`OFS_TRIG, 32'h40);
    wr(`OFS_CTRL, 32'h1);
    meas(8, 12, 2, 0);
    wr(`OFS_TRIG, 32'h0);
    meas(8, 12, 0, 0);
    wr(`OFS_TRIG, 32'h40);
    wr(`OFS_CTRL, 32'h3);
    meas(8, 8, 2, 20);
    wr(`OFS_CTRL, 32'h5);
    meas(4, 4, 2, 12);
    // reserved pin mode keeps both switches off
    wr(`OFS_CTRL, 32'h7);
    meas(0, 0, 2, 20);
    wr(`OFS_PHASE, 32'h5);
    wr(`OFS_CTRL, 32'h9);
    meas(0, 20, 2, 0);
    wr(`OFS_PHASE, 32'h0);
    wr(`OFS_CTRL, 32'h11);
    for (int i = 0; i < 10; i++) begin
      code = (i < 4) ? i : (i < 8) ? i + 4 : (i == 8) ? 13 : 15;
      wr(`OFS_FCL, 32'(code * 8 + 1));
      fault_req <= 10'(1 << i);
      meas(0, 20, 2, 0);
      fault_req <= 10'h000;
      meas(8, 12, 2, 0);
    end
    wr(`OFS_FCL, 32'h45);
    meas(0, 20, 2, 0);
    fault_req <= 10'h3FF;
    meas(8, 12, 2, 0);
    foreach (quiet[k]) begin
      wr(`OFS_FCL, quiet[k]);
      meas(8, 12, 2, 0);
    end
    fault_req <= 10'h000;
    wr(`OFS_FCL, 32'h0);
    wr(`OFS_CTRL, 32'h21);
    fault_req <= 10'h001;
    repeat (10) @(posedge aclk);
    fault_req <= 10'h000;
    meas(20, 0, 2, 0);
    wr(`OFS_CTRL, 32'h121);
    meas(8, 12, 2, 0);
    wr(`OFS_FCL, 32'h1);
    wr(`OFS_CTRL, 32'h11);
    wr(`OFS_LEB, 32'h8BF8);
    repeat (12) @(posedge aclk);
    fault_req <= 10'h001;
    meas(8, 12, 2, 0);
    wr(`OFS_LEB, 32'h0BF8);
    meas(0, 20, 2, 0);
    fault_req <= 10'h000;
    wr(`OFS_LEB, 32'h0);
    wr(`OFS_FCL, 32'h283);
    wr(`OFS_CTRL, 32'h41);
    // fault line active too: mode 11 must leave the limit data in charge
    fault_req <= 10'h003;
    meas(0, 20, 2, 0);
    fault_req <= 10'h000;
    wr(`OFS_LEB, 32'h87F8);
    repeat (30) @(posedge aclk);
    fault_req <= 10'h002;
    meas(8, 12, 2, 0);
    test_done();
  end
endmodule : tb

`default_nettype wire
